//--- rtl/guest_csr_pkg.sv
// Shared constants and types for the guest supervisor register bank
package guest_csr_pkg;
  // Register width and access selection
  localparam int XLEN = 64;
  typedef enum logic [1:0] {SEL_STATUS, SEL_PENDING, SEL_ENABLE, SEL_VECTOR} csr_sel_type;
  // Status field positions
  localparam int POS_SIE = 1;
  localparam int POS_SPIE = 5;
  localparam int POS_BIG_END = 6;
  localparam int POS_SPP = 8;
  localparam int POS_VEC_CTX = 9;
  localparam int POS_FLT_CTX = 13;
  localparam int POS_EXT_SUM = 15;
  localparam int POS_SUM = 18;
  localparam int POS_MXR = 19;
  localparam int POS_LPAD = 23;
  localparam int POS_DIS_TRAP = 24;
  localparam int POS_SD32 = 31;
  localparam int POS_USER_WIDTH = 32;
  localparam int POS_SD64 = 63;
  // Context state encodings
  localparam logic [1:0] CTX_OFF = 2'h0;
  localparam logic [1:0] CTX_DIRTY = 2'h3;
  localparam logic [1:0] EXT_SUM_NONE = 2'h0;
  // Width encodings, same as the machine width field
  localparam logic [1:0] WIDTH_32 = 2'h1;
  localparam logic [1:0] WIDTH_64 = 2'h2;
  localparam logic [1:0] USER_WIDTH_RESET = WIDTH_64;
  localparam logic USER_WIDTH_FIXED = 1'b0;
  // Counter-overflow delegation present
  localparam logic HAS_LCOF_DELEG = 1'b1;
  // Aliased interrupts: soft, timer, external, counter overflow
  localparam int NUM_ALIAS = 4;
  localparam int AL_LCOF = 3;
  localparam int IRQ_POS [NUM_ALIAS] = '{1, 5, 9, 13};
  localparam int DLG_POS [NUM_ALIAS] = '{2, 6, 10, 13};
  localparam logic [3:0] PEND_WRITABLE = 4'h9;
  // Trap vector mode
  localparam int TVEC_MODE_W = 2;
  localparam logic [1:0] TVEC_MODE_MAX = 2'h1;
  localparam logic [63:0] LOW32_MASK = 64'h0000_0000_FFFF_FFFF;
endpackage : guest_csr_pkg

//--- rtl/ctx_guard.sv
// Floating-point or vector context guard for virtualized execution
`timescale 1ns/10ps
module ctx_guard (
  input wire logic virt,
  input wire logic instr,
  input wire logic modify,
  input wire logic [1:0] guest_state,
  input wire logic [1:0] host_state,
  output logic illegal,
  output logic guest_dirty,
  output logic host_dirty,
  input wire logic clk,
  input wire logic rst_n
);
  import guest_csr_pkg::*;

  // Either field Off traps; guest field only counts while virtualized
  always_comb begin
    illegal = instr && ((host_state == CTX_OFF) || (virt && guest_state == CTX_OFF));
    guest_dirty = virt && modify;
    host_dirty = virt && modify;
  end

  // Guest field Off under virtualization always traps
  guest_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    virt && instr && guest_state == CTX_OFF |-> illegal)
    else $error("guest off did not trap");
  // Outside virtualization the guest field has no say
  host_only_a: assert property (@(posedge clk) disable iff (!rst_n)
    !virt && host_state != CTX_OFF |-> !illegal)
    else $error("guest field trapped while not virtualized");
endmodule : ctx_guard

//--- rtl/guest_csr_bank.sv
// Guest supervisor status, interrupt and trap-vector register bank
// How it works
// - Virtualized status accesses hit the guest copy
// - 32-bit guest width hides user width field
// - 64-bit guest: user width WARL at 33:32
// - Width growth resets user width to widest
// - Float Off in either field traps
// - Virtualized float change dirties both fields
// - Vector Off in either field traps
// - Virtualized vector change dirties both fields
// - Summary bits read-only, guest view only
// - User big-endian mirrors hypervisor guest bit
// - Guest status inert unless acting virtualized
// - Landing pad bit: one means expected
// - Disable-trap bit stored at position 24
// - Virtualized interrupt accesses hit guest copies
// - Delegation bit 13 writable only if implemented
// - Counter overflow bits alias or read zero
// - External bits alias hypervisor or read zero
// - Timer bits alias hypervisor or read zero
// - Software bits alias hypervisor or read zero
// - Only 13, 9, 5, 1 nonzero in low half
// - Virtualized vector accesses hit guest register
`timescale 1ns/10ps
module guest_csr_bank (
  input wire logic REF_CLK,
  input wire logic NRST,
  // Virtualization state
  input wire logic VIRT_MODE,
  input wire logic EMUL_VIRT,
  input wire logic [1:0] HYPER_GUEST_WIDTH,
  input wire logic HYPER_GUEST_BIG_ENDIAN,
  // CSR access path
  input wire logic CSR_VALID,
  input wire guest_csr_pkg::csr_sel_type CSR_SEL,
  input wire logic CSR_WRITE,
  input wire logic [63:0] CSR_WDATA,
  output logic CSR_TO_HOST,
  output logic CSR_RVALID,
  output logic [63:0] CSR_RDATA,
  // Delegation register bits
  input wire logic DELEG_WRITE,
  input wire logic [63:0] DELEG_WDATA,
  output logic [63:0] DELEG_RDATA,
  // Aliased hypervisor pending and enable bits
  input wire logic [3:0] ALIAS_PENDING_IN,
  input wire logic [3:0] ALIAS_ENABLE_IN,
  output logic ALIAS_PENDING_WE,
  output logic [3:0] ALIAS_PENDING_MASK,
  output logic [3:0] ALIAS_PENDING_DATA,
  output logic ALIAS_ENABLE_WE,
  output logic [3:0] ALIAS_ENABLE_MASK,
  output logic [3:0] ALIAS_ENABLE_DATA,
  // Floating-point and vector context
  input wire logic FP_INSTR,
  input wire logic FP_MODIFY,
  input wire logic [1:0] HOST_FLOAT_STATE,
  output logic FP_ILLEGAL,
  output logic HOST_FLOAT_DIRTY,
  input wire logic VEC_INSTR,
  input wire logic VEC_MODIFY,
  input wire logic [1:0] HOST_VECTOR_STATE,
  output logic VEC_ILLEGAL,
  output logic HOST_VECTOR_DIRTY,
  // Guest state towards the core
  output logic GUEST_ACTIVE,
  output logic [63:0] GUEST_STATUS,
  output logic [1:0] GUEST_USER_WIDTH,
  output logic GUEST_TVEC_ACTIVE,
  output logic [63:0] GUEST_TVEC
);
  import guest_csr_pkg::*;

  // Whole bank state
  typedef struct packed {
    logic [1:0] flt_ctx; // Float context state
    logic [1:0] vec_ctx; // Vector context state
    logic sie; // Interrupt enable
    logic spie; // Previous interrupt enable
    logic spp; // Previous privilege
    logic sum; // User memory access
    logic mxr; // Executable readable
    logic lpad; // Previous landing pad expect
    logic dis_trap; // Supervisor disable trap
    logic [1:0] user_width; // Guest user width
    logic [1:0] prev_width; // Width seen last cycle
    logic [63:0] tvec;      // Trap vector
    logic [3:0] deleg;      // Delegation bits per alias
    logic [63:0] rdata;     // Read answer
    logic rvalid;           // Read answer strobe
    logic [1:0] rsel;       // Register behind last answer
    logic ip_we;            // Pending alias write strobe
    logic [3:0] ip_mask;    // Pending alias write mask
    logic [3:0] ip_data;    // Pending alias write data
    logic ie_we;            // Enable alias write strobe
    logic [3:0] ie_mask;    // Enable alias write mask
    logic [3:0] ie_data;    // Enable alias write data
  } bank_state_type;

  bank_state_type state_r;   // Registered state
  bank_state_type state_nxt; // Next state
  logic wide;                // Guest width is 64
  logic [63:0] status_view;  // Status as software sees it
  logic [63:0] pend_view;    // Pending as software sees it
  logic [63:0] en_view;      // Enable as software sees it
  logic [1:0] guard_instr;   // Float, vector instruction
  logic [1:0] guard_modify;  // Float, vector change
  logic [1:0] guard_illegal; // Trap per context
  logic [1:0] guard_gdirty;  // Guest dirty per context
  logic [1:0] guard_hdirty;  // Host dirty per context
  logic [1:0] guard_guest [2];
  logic [1:0] guard_host [2];

  // Build the status view for a width
  function automatic logic [63:0] status_read(input bank_state_type s, input logic w64,
                                              input logic big_end);
    logic [63:0] v;
    logic dirty_sum;
    v = 64'h0;
    dirty_sum = (s.flt_ctx == CTX_DIRTY) || (s.vec_ctx == CTX_DIRTY)
                || (EXT_SUM_NONE == CTX_DIRTY);
    v[POS_SIE] = s.sie;
    v[POS_SPIE] = s.spie;
    v[POS_BIG_END] = big_end;
    v[POS_SPP] = s.spp;
    v[POS_VEC_CTX +: 2] = s.vec_ctx;
    v[POS_FLT_CTX +: 2] = s.flt_ctx;
    v[POS_EXT_SUM +: 2] = EXT_SUM_NONE;
    v[POS_SUM] = s.sum;
    v[POS_MXR] = s.mxr;
    v[POS_LPAD] = s.lpad;
    v[POS_DIS_TRAP] = s.dis_trap;
    if (w64) begin
      v[POS_USER_WIDTH +: 2] = s.user_width;
      v[POS_SD64] = dirty_sum;
    end else begin
      v[POS_SD32] = dirty_sum;
    end
    return v;
  endfunction : status_read

  // Place four alias bits at their interrupt positions
  function automatic logic [63:0] irq_place(input logic [3:0] bits);
    logic [63:0] v;
    v = 64'h0;
    for (int i = 0; i < NUM_ALIAS; i++) begin
      v[IRQ_POS[i]] = bits[i];
    end
    return v;
  endfunction : irq_place

  // Pick four alias bits from their interrupt positions
  function automatic logic [3:0] irq_pick(input logic [63:0] word);
    logic [3:0] v;
    v = 4'h0;
    for (int i = 0; i < NUM_ALIAS; i++) begin
      v[i] = word[IRQ_POS[i]];
    end
    return v;
  endfunction : irq_pick

  // Context guards for float and vector
  assign guard_instr = {VEC_INSTR, FP_INSTR};
  assign guard_modify = {VEC_MODIFY, FP_MODIFY};
  assign guard_guest[0] = state_r.flt_ctx;
  assign guard_guest[1] = state_r.vec_ctx;
  assign guard_host[0] = HOST_FLOAT_STATE;
  assign guard_host[1] = HOST_VECTOR_STATE;
  generate
    for (genvar g = 0; g < 2; g++) begin : gen_guard
      ctx_guard u_guard (
        .virt(VIRT_MODE),
        .instr(guard_instr[g]),
        .modify(guard_modify[g]),
        .guest_state(guard_guest[g]),
        .host_state(guard_host[g]),
        .illegal(guard_illegal[g]),
        .guest_dirty(guard_gdirty[g]),
        .host_dirty(guard_hdirty[g]),
        .clk(REF_CLK),
        .rst_n(NRST)
      );
    end
  endgenerate

  // Current software views
  always_comb begin
    wide = (HYPER_GUEST_WIDTH == WIDTH_64);
    status_view = status_read(state_r, wide, HYPER_GUEST_BIG_ENDIAN);
    pend_view = irq_place(ALIAS_PENDING_IN & state_r.deleg);
    en_view = irq_place(ALIAS_ENABLE_IN & state_r.deleg);
  end

  // Next-state logic
  always_comb begin
    logic [3:0] dbits;
    logic [1:0] wuxl;
    logic [63:0] wdata;
    logic acc;
    dbits = 4'h0;
    wuxl = 2'h0;
    wdata = wide ? CSR_WDATA : (CSR_WDATA & LOW32_MASK);
    acc = CSR_VALID && VIRT_MODE;
    state_nxt = state_r;
    state_nxt.rvalid = acc;
    state_nxt.ip_we = 1'b0;
    state_nxt.ie_we = 1'b0;
    state_nxt.prev_width = HYPER_GUEST_WIDTH;
    // Read answer holds the value before any write
    if (acc) begin
      state_nxt.rsel = CSR_SEL;
      case (CSR_SEL)
        SEL_STATUS: state_nxt.rdata = status_view;
        SEL_PENDING: state_nxt.rdata = pend_view;
        SEL_ENABLE: state_nxt.rdata = en_view;
        SEL_VECTOR: state_nxt.rdata = wide ? state_r.tvec : (state_r.tvec & LOW32_MASK);
        default: state_nxt.rdata = 64'h0;
      endcase
    end
    // Guest register writes
    if (acc && CSR_WRITE) begin
      case (CSR_SEL)
        SEL_STATUS: begin
          state_nxt.sie = wdata[POS_SIE];
          state_nxt.spie = wdata[POS_SPIE];
          state_nxt.spp = wdata[POS_SPP];
          state_nxt.vec_ctx = wdata[POS_VEC_CTX +: 2];
          state_nxt.flt_ctx = wdata[POS_FLT_CTX +: 2];
          state_nxt.sum = wdata[POS_SUM];
          state_nxt.mxr = wdata[POS_MXR];
          state_nxt.lpad = wdata[POS_LPAD];
          state_nxt.dis_trap = wdata[POS_DIS_TRAP];
          wuxl = wdata[POS_USER_WIDTH +: 2];
          // Only supported widths stick
          if (wide && !USER_WIDTH_FIXED && (wuxl == WIDTH_32 || wuxl == WIDTH_64)) begin
            state_nxt.user_width = wuxl;
          end
        end
        SEL_PENDING: begin
          state_nxt.ip_we = 1'b1;
          state_nxt.ip_mask = state_r.deleg & PEND_WRITABLE;
          state_nxt.ip_data = irq_pick(wdata);
        end
        SEL_ENABLE: begin
          state_nxt.ie_we = 1'b1;
          state_nxt.ie_mask = state_r.deleg;
          state_nxt.ie_data = irq_pick(wdata);
        end
        SEL_VECTOR: begin
          state_nxt.tvec = wdata;
          // Unsupported modes keep the old mode
          if (wdata[TVEC_MODE_W-1:0] > TVEC_MODE_MAX) begin
            state_nxt.tvec[TVEC_MODE_W-1:0] = state_r.tvec[TVEC_MODE_W-1:0];
          end
        end
        default: state_nxt.tvec = state_r.tvec;
      endcase
    end
    // Hardware dirty marking wins over a write
    if (guard_gdirty[0]) begin
      state_nxt.flt_ctx = CTX_DIRTY;
    end
    if (guard_gdirty[1]) begin
      state_nxt.vec_ctx = CTX_DIRTY;
    end
    // Width growth from 32 picks the widest width
    if (!USER_WIDTH_FIXED && state_r.prev_width == WIDTH_32 && wide) begin
      state_nxt.user_width = WIDTH_64;
    end
    // Delegation bits, bit 13 only when present
    if (DELEG_WRITE) begin
      for (int i = 0; i < NUM_ALIAS; i++) begin
        dbits[i] = DELEG_WDATA[DLG_POS[i]];
      end
      dbits[AL_LCOF] = dbits[AL_LCOF] && HAS_LCOF_DELEG;
      state_nxt.deleg = dbits;
    end
  end

  // State register
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      state_r <= '0;
      state_r.user_width <= USER_WIDTH_RESET;
      state_r.prev_width <= WIDTH_64;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Outputs
  always_comb begin
    CSR_TO_HOST = CSR_VALID && !VIRT_MODE;
    CSR_RVALID = state_r.rvalid;
    CSR_RDATA = state_r.rdata;
    DELEG_RDATA = '0;
    for (int i = 0; i < NUM_ALIAS; i++) begin
      DELEG_RDATA[DLG_POS[i]] = state_r.deleg[i];
    end
    ALIAS_PENDING_WE = state_r.ip_we;
    ALIAS_PENDING_MASK = state_r.ip_mask;
    ALIAS_PENDING_DATA = state_r.ip_data;
    ALIAS_ENABLE_WE = state_r.ie_we;
    ALIAS_ENABLE_MASK = state_r.ie_mask;
    ALIAS_ENABLE_DATA = state_r.ie_data;
    FP_ILLEGAL = guard_illegal[0];
    VEC_ILLEGAL = guard_illegal[1];
    HOST_FLOAT_DIRTY = guard_hdirty[0];
    HOST_VECTOR_DIRTY = guard_hdirty[1];
    GUEST_ACTIVE = VIRT_MODE || EMUL_VIRT;
    GUEST_STATUS = GUEST_ACTIVE ? status_view : 64'h0;
    GUEST_USER_WIDTH = wide ? state_r.user_width : WIDTH_32;
    GUEST_TVEC_ACTIVE = VIRT_MODE;
    GUEST_TVEC = state_r.tvec;
  end

  // Checks
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!NRST);

  status_write_a: assert property (
    CSR_VALID && VIRT_MODE && CSR_WRITE && CSR_SEL == SEL_STATUS && !FP_MODIFY
    |=> state_r.flt_ctx == $past(CSR_WDATA[POS_FLT_CTX +: 2]))
    else $error("status write not taken");
  host_route_a: assert property (
    CSR_VALID && !VIRT_MODE && !FP_MODIFY && !VEC_MODIFY |=> $stable(state_r.flt_ctx)
    && $stable(state_r.tvec) && !CSR_RVALID)
    else $error("guest bank changed while not virtualized");
  narrow_user_a: assert property (
    HYPER_GUEST_WIDTH == WIDTH_32 |-> GUEST_USER_WIDTH == WIDTH_32
    && GUEST_STATUS[POS_USER_WIDTH +: 2] == 2'h0)
    else $error("user width seen at 32-bit guest width");
  width_grow_a: assert property (
    HYPER_GUEST_WIDTH == WIDTH_32 ##1 HYPER_GUEST_WIDTH == WIDTH_64
    |=> state_r.user_width == WIDTH_64)
    else $error("user width not widened");
  float_dirty_a: assert property (
    VIRT_MODE && FP_MODIFY |-> HOST_FLOAT_DIRTY ##1 state_r.flt_ctx == CTX_DIRTY)
    else $error("float context not dirtied");
  vector_dirty_a: assert property (
    VIRT_MODE && VEC_MODIFY |-> HOST_VECTOR_DIRTY ##1 state_r.vec_ctx == CTX_DIRTY)
    else $error("vector context not dirtied");
  summary_bit_a: assert property (
    CSR_VALID && VIRT_MODE && CSR_SEL == SEL_STATUS && wide
    |=> CSR_RDATA[POS_SD64] == ($past(state_r.flt_ctx) == CTX_DIRTY
    || $past(state_r.vec_ctx) == CTX_DIRTY))
    else $error("summary bit wrong");
  deleg_lcof_a: assert property (
    DELEG_WRITE |=> DELEG_RDATA[DLG_POS[AL_LCOF]]
    == ($past(DELEG_WDATA[DLG_POS[AL_LCOF]]) && HAS_LCOF_DELEG))
    else $error("delegation bit 13 wrong");
  alias_zero_a: assert property (
    CSR_VALID && VIRT_MODE && CSR_SEL == SEL_PENDING && !state_r.deleg[AL_LCOF]
    |=> CSR_RVALID && !CSR_RDATA[IRQ_POS[AL_LCOF]])
    else $error("undelegated overflow bit visible");
  std_zero_a: assert property (
    CSR_RVALID && state_r.rsel inside {SEL_PENDING, SEL_ENABLE}
    |-> (CSR_RDATA[15:0] & 16'hDDDD) == 16'h0)
    else $error("nonstandard interrupt bit set");
  tvec_mode_a: assert property (
    GUEST_TVEC[TVEC_MODE_W-1:0] <= TVEC_MODE_MAX)
    else $error("illegal vector mode held");

  status_read_c: cover property (CSR_VALID && VIRT_MODE && CSR_SEL == SEL_STATUS ##1 CSR_RVALID);
  enable_write_c: cover property (CSR_VALID && VIRT_MODE && CSR_WRITE && CSR_SEL == SEL_ENABLE);
  float_trap_c: cover property (VIRT_MODE && FP_ILLEGAL);
  width_grow_c: cover property (HYPER_GUEST_WIDTH == WIDTH_32 ##1 HYPER_GUEST_WIDTH == WIDTH_64);
endmodule : guest_csr_bank

//--- tb/hyper_irq_model.sv
// Hypervisor-side pending and enable bits that the guest bank aliases
`timescale 1ns/10ps
module hyper_irq_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pend_we,
  input wire logic [3:0] pend_mask,
  input wire logic [3:0] pend_data,
  input wire logic en_we,
  input wire logic [3:0] en_mask,
  input wire logic [3:0] en_data,
  input wire logic [3:0] hw_raise,
  output logic [3:0] pend_q,
  output logic [3:0] en_q
);
  logic [3:0] pend_r; // Stored pending bits, bit0 soft
  logic [3:0] en_r; // Stored enable bits
  // Hardware sources stay visible whatever software writes
  assign pend_q = pend_r | hw_raise;
  assign en_q = en_r;
  // Forwarded guest writes only touch masked bits
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_r <= 4'h0;
      en_r <= 4'h0;
    end else begin
      if (pend_we) begin
        pend_r <= (pend_r & ~pend_mask) | (pend_data & pend_mask);
      end
      if (en_we) begin
        en_r <= (en_r & ~en_mask) | (en_data & en_mask);
      end
    end
  end
endmodule : hyper_irq_model

//--- tb/guest_supervisor_csr_bank_test.sv
// Self-checking bench for the guest supervisor register bank
`timescale 1ns/10ps
module guest_supervisor_csr_bank_test;
  import guest_csr_pkg::*;
  typedef struct packed {csr_sel_type sel; logic [63:0] wd; logic [63:0] exp;} row_type;
  logic REF_CLK = 1'b0, NRST = 1'b0, VIRT_MODE = 1'b1, EMUL_VIRT = 1'b0;
  logic [1:0] HYPER_GUEST_WIDTH = WIDTH_64;
  logic HYPER_GUEST_BIG_ENDIAN = 1'b0, CSR_VALID = 1'b0, CSR_WRITE = 1'b0;
  csr_sel_type CSR_SEL = SEL_STATUS;
  logic [63:0] CSR_WDATA = 64'h0, DELEG_WDATA = 64'h0, CSR_RDATA, DELEG_RDATA;
  logic [63:0] GUEST_STATUS, GUEST_TVEC, rd, prev_stat, prev_tvec;
  logic DELEG_WRITE = 1'b0, FP_INSTR = 1'b0, FP_MODIFY = 1'b0;
  logic VEC_INSTR = 1'b0, VEC_MODIFY = 1'b0;
  logic [1:0] HOST_FLOAT_STATE = 2'h0, HOST_VECTOR_STATE = 2'h0, GUEST_USER_WIDTH;
  logic [3:0] ALIAS_PENDING_IN, ALIAS_ENABLE_IN, ALIAS_PENDING_MASK, ALIAS_PENDING_DATA;
  logic [3:0] ALIAS_ENABLE_MASK, ALIAS_ENABLE_DATA, hw_raise = 4'h6;
  logic CSR_TO_HOST, CSR_RVALID, ALIAS_PENDING_WE, ALIAS_ENABLE_WE, FP_ILLEGAL, VEC_ILLEGAL;
  logic HOST_FLOAT_DIRTY, HOST_VECTOR_DIRTY, GUEST_ACTIVE, GUEST_TVEC_ACTIVE;
  int fails = 0, num_checks = 0;
  // Ordinary writes: selector, written value, resulting register view
  row_type rows [8] = '{
    '{SEL_STATUS, 64'hFFFF_FFFF_FFFF_FFFF, 64'h8000_0002_018C_6722},
    '{SEL_STATUS, 64'h0000_0001_0000_0000, 64'h0000_0001_0000_0000},
    '{SEL_STATUS, 64'h0000_0002_0000_6000, 64'h8000_0002_0000_6000},
    '{SEL_STATUS, 64'h0000_0002_0000_0600, 64'h8000_0002_0000_0600},
    '{SEL_STATUS, 64'h0000_0003_0180_2000, 64'h0000_0002_0180_2000},
    '{SEL_VECTOR, 64'h0000_0000_8000_0001, 64'h0000_0000_8000_0001},
    '{SEL_VECTOR, 64'h1234_5678_9ABC_DEF2, 64'h1234_5678_9ABC_DEF1},
    '{SEL_STATUS, 64'h0000_0001_0000_6000, 64'h8000_0001_0000_6000}};
  guest_csr_bank u_guest_csr_bank (.REF_CLK(REF_CLK), .NRST(NRST), .VIRT_MODE(VIRT_MODE),
    .EMUL_VIRT(EMUL_VIRT), .HYPER_GUEST_WIDTH(HYPER_GUEST_WIDTH),
    .HYPER_GUEST_BIG_ENDIAN(HYPER_GUEST_BIG_ENDIAN), .CSR_VALID(CSR_VALID), .CSR_SEL(CSR_SEL),
    .CSR_WRITE(CSR_WRITE), .CSR_WDATA(CSR_WDATA), .CSR_TO_HOST(CSR_TO_HOST),
    .CSR_RVALID(CSR_RVALID), .CSR_RDATA(CSR_RDATA), .DELEG_WRITE(DELEG_WRITE),
    .DELEG_WDATA(DELEG_WDATA), .DELEG_RDATA(DELEG_RDATA), .ALIAS_PENDING_IN(ALIAS_PENDING_IN),
    .ALIAS_ENABLE_IN(ALIAS_ENABLE_IN), .ALIAS_PENDING_WE(ALIAS_PENDING_WE),
    .ALIAS_PENDING_MASK(ALIAS_PENDING_MASK), .ALIAS_PENDING_DATA(ALIAS_PENDING_DATA),
    .ALIAS_ENABLE_WE(ALIAS_ENABLE_WE), .ALIAS_ENABLE_MASK(ALIAS_ENABLE_MASK),
    .ALIAS_ENABLE_DATA(ALIAS_ENABLE_DATA), .FP_INSTR(FP_INSTR), .FP_MODIFY(FP_MODIFY),
    .HOST_FLOAT_STATE(HOST_FLOAT_STATE), .FP_ILLEGAL(FP_ILLEGAL),
    .HOST_FLOAT_DIRTY(HOST_FLOAT_DIRTY), .VEC_INSTR(VEC_INSTR), .VEC_MODIFY(VEC_MODIFY),
    .HOST_VECTOR_STATE(HOST_VECTOR_STATE), .VEC_ILLEGAL(VEC_ILLEGAL),
    .HOST_VECTOR_DIRTY(HOST_VECTOR_DIRTY), .GUEST_ACTIVE(GUEST_ACTIVE),
    .GUEST_STATUS(GUEST_STATUS), .GUEST_USER_WIDTH(GUEST_USER_WIDTH),
    .GUEST_TVEC_ACTIVE(GUEST_TVEC_ACTIVE), .GUEST_TVEC(GUEST_TVEC));
  hyper_irq_model u_hyper_irq_model (.clk(REF_CLK), .rst_n(NRST), .pend_we(ALIAS_PENDING_WE),
    .pend_mask(ALIAS_PENDING_MASK), .pend_data(ALIAS_PENDING_DATA), .en_we(ALIAS_ENABLE_WE),
    .en_mask(ALIAS_ENABLE_MASK), .en_data(ALIAS_ENABLE_DATA), .hw_raise(hw_raise),
    .pend_q(ALIAS_PENDING_IN), .en_q(ALIAS_ENABLE_IN));
  // Core clock, 25 ns period
  initial begin
    forever #12.5 REF_CLK = ~REF_CLK;
  end
  // Compare a word
  task automatic chk64(input string what, input logic [63:0] exp, input logic [63:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk64
  // Compare a flag
  task automatic chk1(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask : chk1
  // One register access, answer sampled in the cycle after the taking edge
  task automatic access(input csr_sel_type sel, input logic wr, input logic [63:0] wd,
                        output logic [63:0] data);
    @(negedge REF_CLK);
    CSR_VALID = 1'b1;
    CSR_SEL = sel;
    CSR_WRITE = wr;
    CSR_WDATA = wd;
    @(negedge REF_CLK);
    CSR_VALID = 1'b0;
    CSR_WRITE = 1'b0;
    chk1("answer valid", 1'b1, CSR_RVALID);
    data = CSR_RDATA;
  endtask : access
  // Delegation bits write
  task automatic deleg(input logic [63:0] v);
    @(negedge REF_CLK);
    DELEG_WRITE = 1'b1;
    DELEG_WDATA = v;
    @(negedge REF_CLK);
    DELEG_WRITE = 1'b0;
  endtask : deleg
  // Verdict and end of run
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test
  // Watchdog, far beyond the fewer than one hundred cycles of the tests
  initial begin
    #(25 * 5000);
    fails++;
    stop_test();
  end
  // Main sequence
  initial begin
    repeat (3) @(negedge REF_CLK);
    NRST = 1'b1;
    chk64("reset status", 64'h0000_0002_0000_0000, GUEST_STATUS);
    chk64("reset vector", 64'h0, GUEST_TVEC);
    chk64("reset deleg", 64'h0, DELEG_RDATA);
    chk1("reset answer", 1'b0, CSR_RVALID);
    chk1("vector active", 1'b1, GUEST_TVEC_ACTIVE);
    prev_stat = 64'h0000_0002_0000_0000;
    prev_tvec = 64'h0;
    // Table of ordinary status and trap-vector writes
    foreach (rows[i]) begin
      access(rows[i].sel, 1'b1, rows[i].wd, rd);
      if (rows[i].sel == SEL_STATUS) begin
        chk64("status old", prev_stat, rd);
        chk64("status new", rows[i].exp, GUEST_STATUS);
        prev_stat = rows[i].exp;
      end else begin
        chk64("vector old", prev_tvec, rd);
        chk64("vector new", rows[i].exp, GUEST_TVEC);
        prev_tvec = rows[i].exp;
      end
    end
    // Narrow guest width, then widen again
    HYPER_GUEST_WIDTH = WIDTH_32;
    @(negedge REF_CLK);
    chk64("user width narrow", 64'h1, {62'h0, GUEST_USER_WIDTH});
    chk64("status narrow", 64'h0000_0000_8000_6000, GUEST_STATUS);
    HYPER_GUEST_WIDTH = WIDTH_64;
    repeat (2) @(negedge REF_CLK);
    chk64("user width wide", 64'h2, {62'h0, GUEST_USER_WIDTH});
    HYPER_GUEST_BIG_ENDIAN = 1'b1;
    @(negedge REF_CLK);
    chk1("big endian mirror", 1'b1, GUEST_STATUS[POS_BIG_END]);
    // Access while not virtualized goes to the host copy
    VIRT_MODE = 1'b0;
    CSR_VALID = 1'b1;
    CSR_WRITE = 1'b1;
    CSR_SEL = SEL_STATUS;
    CSR_WDATA = 64'h0;
    #1 chk1("to host", 1'b1, CSR_TO_HOST);
    chk64("inert status", 64'h0, GUEST_STATUS);
    chk1("vector inactive", 1'b0, GUEST_TVEC_ACTIVE);
    chk1("guest inactive", 1'b0, GUEST_ACTIVE);
    @(negedge REF_CLK);
    CSR_VALID = 1'b0;
    CSR_WRITE = 1'b0;
    EMUL_VIRT = 1'b1;
    #1 chk1("no answer", 1'b0, CSR_RVALID);
    chk64("emulated status", 64'h8000_0002_0000_6040, GUEST_STATUS);
    chk1("guest active", 1'b1, GUEST_ACTIVE);
    @(negedge REF_CLK);
    EMUL_VIRT = 1'b0;
    VIRT_MODE = 1'b1;
    // Context traps: guest float Dirty, guest vector Off
    FP_INSTR = 1'b1;
    VEC_INSTR = 1'b1;
    for (int h = 0; h < 4; h++) begin
      HOST_FLOAT_STATE = 2'(h);
      HOST_VECTOR_STATE = 2'(h);
      #1 chk1("float trap", h == 0, FP_ILLEGAL);
      chk1("vector trap", 1'b1, VEC_ILLEGAL);
      @(negedge REF_CLK);
    end
    FP_MODIFY = 1'b1;
    VEC_MODIFY = 1'b1;
    #1 chk1("host float dirty", 1'b1, HOST_FLOAT_DIRTY);
    chk1("host vector dirty", 1'b1, HOST_VECTOR_DIRTY);
    @(negedge REF_CLK);
    {FP_INSTR, VEC_INSTR, FP_MODIFY, VEC_MODIFY} = 4'h0;
    chk64("guest dirty", 64'h8000_0002_0000_6640, GUEST_STATUS);
    // Dirty marking beats a status write in the same cycle
    FP_MODIFY = 1'b1;
    access(SEL_STATUS, 1'b1, 64'h0000_0002_0000_0000, rd);
    FP_MODIFY = 1'b0;
    chk64("status before", 64'h8000_0002_0000_6640, rd);
    chk64("dirty beats write", 64'h8000_0002_0000_6040, GUEST_STATUS);
    // Interrupt aliasing, one delegation bit at a time
    access(SEL_PENDING, 1'b0, 64'h0, rd);
    chk64("pending undelegated", 64'h0, rd);
    for (int i = 0; i < NUM_ALIAS; i++) begin
      deleg(64'h1 << DLG_POS[i]);
      access(SEL_ENABLE, 1'b1, 64'hFFFF_FFFF_FFFF_FFFF, rd);
      chk1("enable strobe", 1'b1, ALIAS_ENABLE_WE);
      chk64("enable mask", 64'h1 << i, {60'h0, ALIAS_ENABLE_MASK});
      chk64("enable data", 64'hF, {60'h0, ALIAS_ENABLE_DATA});
      access(SEL_ENABLE, 1'b0, 64'h0, rd);
      chk64("enable alias", 64'h1 << IRQ_POS[i], rd);
      access(SEL_PENDING, 1'b0, 64'h0, rd);
      chk64("pending alias", hw_raise[i] ? 64'h1 << IRQ_POS[i] : 64'h0, rd);
    end
    deleg(64'hFFFF_FFFF_FFFF_FFFF);
    chk64("deleg bits", 64'h2444, DELEG_RDATA);
    access(SEL_PENDING, 1'b1, 64'hFFFF_FFFF_FFFF_FFFF, rd);
    chk64("pending mask", 64'h9, {60'h0, ALIAS_PENDING_MASK});
    chk64("pending data", 64'hF, {60'h0, ALIAS_PENDING_DATA});
    chk1("pending strobe", 1'b1, ALIAS_PENDING_WE);
    access(SEL_PENDING, 1'b0, 64'h0, rd);
    chk64("pending all", 64'h2222, rd);
    access(SEL_ENABLE, 1'b0, 64'h0, rd);
    chk64("enable all", 64'h2222, rd);
    // Reset in mid-run clears the bank
    NRST = 1'b0;
    #1 chk64("reset again status", 64'h0000_0002_0000_0040, GUEST_STATUS);
    chk64("reset again deleg", 64'h0, DELEG_RDATA);
    @(negedge REF_CLK);
    NRST = 1'b1;
    access(SEL_ENABLE, 1'b0, 64'h0, rd);
    chk64("enable after reset", 64'h0, rd);
    stop_test();
  end
endmodule : guest_supervisor_csr_bank_test
